//--- gpb_pkg.sv
package gpb_pkg;

  // Port width, one latch bit and one direction bit per pin.
  localparam int unsigned PORT_W = 8;

  // Register word indices; byte address is four times the index.
  localparam logic [3:0] IDX_SECOND_DATA  = 4'h1;
  localparam logic [3:0] IDX_THIRD_DATA   = 4'h2;
  localparam logic [3:0] IDX_FOURTH_DATA  = 4'h3;
  localparam logic [3:0] IDX_SECOND_DIR   = 4'h4;
  localparam logic [3:0] IDX_THIRD_DIR    = 4'h5;
  localparam logic [3:0] IDX_FOURTH_DIR   = 4'h6;
  localparam logic [3:0] IDX_PERIPH_CTRL  = 4'h7;
  localparam logic [3:0] IDX_KBD_ENABLE   = 4'h8;

  // Field positions inside the peripheral control word.
  localparam int unsigned BIT_SPI_EN      = 0;
  localparam int unsigned BIT_IR_EN       = 1;
  localparam int unsigned BIT_PULLUP_DIS  = 2;

  // Reset values.
  localparam logic [7:0] DIR_RESET        = 8'h00;
  localparam logic [7:0] CTRL_RESET       = 8'h00;

  // Pin positions of the shared third-port functions.
  localparam int unsigned PIN_SECOND_EXTERNAL_INTERRUPT        = 0;
  localparam int unsigned PIN_MISO        = 2;
  localparam int unsigned PIN_MOSI        = 3;
  localparam int unsigned PIN_SS          = 4;
  localparam int unsigned PIN_SCK         = 5;
  localparam int unsigned PIN_IR_TX       = 6;
  localparam int unsigned PIN_IR_RX       = 7;

endpackage

//--- gpb_ports.sv
`timescale 1ns/1ns
// What this block does
// - Second port read: latch if output, else pin
// - Third port read: latch if output, else pin
// - Fourth port read: latch if output, else pin
// - Data writes always update the latches
// - Input pin reads unaffected by latch writes
// - Third direction bit enables output buffer
// - Fourth direction bit drives pin from latch
// - Reset clears third port direction bits
// - Reset clears fourth port direction bits
// - Reset keeps third port latches
// - Reset keeps fourth port latches
// - Serial enable hands pins 2-5 over
// - Infrared enable hands pins 6-7 over
// - Pin 0 always feeds interrupt; pullup optional
// - Fourth port pins feed keyboard when enabled
// - Eight pins, latch and direction each
module gpb_ports
  import gpb_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone classic slave.
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [5:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   wb_err_o,
  // Second port pins.
  input  wire logic [7:0]        second_pin_i,
  output logic      [7:0]        second_pin_o,
  output logic      [7:0]        second_pin_oe_o,
  // Third port pins.
  input  wire logic [7:0]        third_pin_i,
  output logic      [7:0]        third_pin_o,
  output logic      [7:0]        third_pin_oe_o,
  output logic                   third_pin0_pullup_o,
  // Fourth port pins.
  input  wire logic [7:0]        fourth_pin_i,
  output logic      [7:0]        fourth_pin_o,
  output logic      [7:0]        fourth_pin_oe_o,
  // Serial peripheral interface side, same clock.
  input  wire logic              spi_miso_out_i,
  input  wire logic              spi_miso_oe_i,
  input  wire logic              spi_mosi_out_i,
  input  wire logic              spi_mosi_oe_i,
  input  wire logic              spi_ss_out_i,
  input  wire logic              spi_ss_oe_i,
  input  wire logic              spi_sck_out_i,
  input  wire logic              spi_sck_oe_i,
  output logic      [3:0]        spi_pins_o,
  // Infrared serial side, same clock.
  input  wire logic              infrared_transmit_line_i,
  output logic                   infrared_receive_line_o,
  // Interrupt module feeds.
  output logic                   second_external_interrupt_o,
  output logic      [7:0]        keyboard_irq_o,
  output logic      [7:0]        keyboard_irq_enable_bits_o
);

  // Registered state: port latches, directions and control words.
  logic [7:0] second_port_data_q;
  logic [7:0] third_port_data_q;
  logic [7:0] fourth_port_data_q;
  logic [7:0] second_port_direction_q;
  logic [7:0] third_port_direction_q;
  logic [7:0] fourth_port_direction_q;
  logic [7:0] periph_ctrl_q;
  logic [7:0] keyboard_irq_enable_reg_q;
  // Two-flop synchronisers for the board pins.
  logic [7:0] second_meta_q;
  logic [7:0] second_sync_q;
  logic [7:0] third_meta_q;
  logic [7:0] third_sync_q;
  logic [7:0] fourth_meta_q;
  logic [7:0] fourth_sync_q;
  // Bus decode and answer.
  logic [7:0] rd_data_d;
  logic [31:0] dat_q;
  logic        ack_q;
  logic        err_q;
  logic        req;
  logic        wr_lane0;
  logic        hit;
  logic [3:0]  idx;
  // Control fields pulled out of the peripheral word.
  logic        serial_periph_enable;
  logic        infrared_serial_enable;
  logic        pin0_pullup_disable;
  logic [7:0] third_gp_oe;

  assign idx = wb_adr_i[5:2];
  // A request is taken only while no answer is pending, so each one is answered once.
  // Writes land at the taking edge; the answer follows one cycle later.
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wr_lane0 = req && wb_we_i && wb_sel_i[0] && hit;
  assign serial_periph_enable = periph_ctrl_q[BIT_SPI_EN];
  assign infrared_serial_enable = periph_ctrl_q[BIT_IR_EN];
  assign pin0_pullup_disable = periph_ctrl_q[BIT_PULLUP_DIS];

  // Pins come from the board, so each passes two flops before any logic reads it.
  // Only the second flop feeds logic, because the first may still be settling.
  always_ff @(posedge clk_i)
  begin
    second_meta_q <= second_pin_i;
    second_sync_q <= second_meta_q;
    third_meta_q  <= third_pin_i;
    third_sync_q  <= third_meta_q;
    fourth_meta_q <= fourth_pin_i;
    fourth_sync_q <= fourth_meta_q;
  end

  // Address decode; everything outside the map answers with an error.
  // An error answer makes a stray access visible instead of silently lost.
  always_comb
  begin
    case (idx)
      IDX_SECOND_DATA, IDX_THIRD_DATA, IDX_FOURTH_DATA,
      IDX_SECOND_DIR, IDX_THIRD_DIR, IDX_FOURTH_DIR,
      IDX_PERIPH_CTRL, IDX_KBD_ENABLE: hit = 1'b1;
      default:                         hit = 1'b0;
    endcase
  end

  // Latches take every write regardless of direction and keep their value over reset.
  // No reset branch on purpose: software may park a value and rely on it after reset.
  // The price is an unknown latch after power-up until the first write.
  always_ff @(posedge clk_i)
  begin
    if (wr_lane0 && idx == IDX_SECOND_DATA)
      second_port_data_q <= wb_dat_i[7:0];
    if (wr_lane0 && idx == IDX_THIRD_DATA)
      third_port_data_q <= wb_dat_i[7:0];
    if (wr_lane0 && idx == IDX_FOURTH_DATA)
      fourth_port_data_q <= wb_dat_i[7:0];
  end

  // Direction and control registers clear on reset so every pin starts as an input.
  // Only byte lane 0 carries a register; other lanes are acknowledged and dropped.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      second_port_direction_q   <= DIR_RESET;
      third_port_direction_q    <= DIR_RESET;
      fourth_port_direction_q   <= DIR_RESET;
      periph_ctrl_q             <= CTRL_RESET;
      keyboard_irq_enable_reg_q <= CTRL_RESET;
    end
    else if (wr_lane0)
    begin
      case (idx)
        IDX_SECOND_DIR:  second_port_direction_q   <= wb_dat_i[7:0];
        IDX_THIRD_DIR:   third_port_direction_q    <= wb_dat_i[7:0];
        IDX_FOURTH_DIR:  fourth_port_direction_q   <= wb_dat_i[7:0];
        IDX_PERIPH_CTRL: periph_ctrl_q             <= {5'h00, wb_dat_i[2:0]};
        IDX_KBD_ENABLE:  keyboard_irq_enable_reg_q <= wb_dat_i[7:0];
        default:         periph_ctrl_q             <= periph_ctrl_q;
      endcase
    end
  end

  // Read mux; data reads blend latch and synchronised pin level per direction bit.
  // Output pins read back the latch, not the pad, so a loaded pin never misreads.
  // Input pins read the synchronised level, two edges behind the pad.
  always_comb
  begin
    case (idx)
      IDX_SECOND_DATA: rd_data_d = (second_port_direction_q & second_port_data_q)
                                 | (~second_port_direction_q & second_sync_q);
      IDX_THIRD_DATA:  rd_data_d = (third_port_direction_q & third_port_data_q)
                                 | (~third_port_direction_q & third_sync_q);
      IDX_FOURTH_DATA: rd_data_d = (fourth_port_direction_q & fourth_port_data_q)
                                 | (~fourth_port_direction_q & fourth_sync_q);
      IDX_SECOND_DIR:  rd_data_d = second_port_direction_q;
      IDX_THIRD_DIR:   rd_data_d = third_port_direction_q;
      IDX_FOURTH_DIR:  rd_data_d = fourth_port_direction_q;
      IDX_PERIPH_CTRL: rd_data_d = periph_ctrl_q;
      IDX_KBD_ENABLE:  rd_data_d = keyboard_irq_enable_reg_q;
      default:         rd_data_d = 8'h00;
    endcase
  end

  // One-cycle answer; ack drops the cycle after it is given.
  // Read data is cleared on writes and idle cycles so the bus never shows stale words.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req && hit;
      err_q <= req && !hit;
      dat_q <= (req && hit && !wb_we_i) ? {24'h00_0000, rd_data_d} : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = dat_q;

  // General-purpose output enables before peripheral override on the third port.
  assign third_gp_oe = third_port_direction_q;

  // Third port pin drive; peripheral enables take the pins away from the port logic.
  // The override is per pin, so the serial enable leaves pins 0, 1, 6 and 7 alone.
  always_comb
  begin
    third_pin_o    = third_port_data_q;
    third_pin_oe_o = third_gp_oe;
    if (serial_periph_enable)
    begin
      third_pin_o[PIN_MISO]    = spi_miso_out_i;
      third_pin_oe_o[PIN_MISO] = spi_miso_oe_i;
      third_pin_o[PIN_MOSI]    = spi_mosi_out_i;
      third_pin_oe_o[PIN_MOSI] = spi_mosi_oe_i;
      third_pin_o[PIN_SS]      = spi_ss_out_i;
      third_pin_oe_o[PIN_SS]   = spi_ss_oe_i;
      third_pin_o[PIN_SCK]     = spi_sck_out_i;
      third_pin_oe_o[PIN_SCK]  = spi_sck_oe_i;
    end
    // Infrared receive never drives; the pin stays an input while the interface owns it.
    if (infrared_serial_enable)
    begin
      third_pin_o[PIN_IR_TX]    = infrared_transmit_line_i;
      third_pin_oe_o[PIN_IR_TX] = 1'b1;
      third_pin_o[PIN_IR_RX]    = 1'b0;
      third_pin_oe_o[PIN_IR_RX] = 1'b0;
    end
  end

  // Peripheral inputs come from synchronised pins; idle high when not enabled.
  // Idle high keeps a disabled receiver from seeing a false start.
  assign spi_pins_o = serial_periph_enable ? third_sync_q[PIN_SCK:PIN_MISO] : 4'hf;
  assign infrared_receive_line_o = infrared_serial_enable ? third_sync_q[PIN_IR_RX] : 1'b1;

  // Pin 0 feeds the interrupt input whatever its port use, so stray edges can interrupt.
  // The pullup output only steers the pad; the level itself is set by the board.
  assign second_external_interrupt_o = third_sync_q[PIN_SECOND_EXTERNAL_INTERRUPT];
  assign third_pin0_pullup_o = !pin0_pullup_disable;

  // Second and fourth ports drive from their latches when set as outputs.
  assign second_pin_o    = second_port_data_q;
  assign second_pin_oe_o = second_port_direction_q;
  assign fourth_pin_o    = fourth_port_data_q;
  assign fourth_pin_oe_o = fourth_port_direction_q;

  // Keyboard inputs are gated per pin so disabled keys never reach the keyboard logic.
  // The enable word is also exported so the keyboard logic can see which keys are live.
  assign keyboard_irq_o = fourth_sync_q & keyboard_irq_enable_reg_q;
  assign keyboard_irq_enable_bits_o = keyboard_irq_enable_reg_q;

  // Assertions.
  // Each one checks behaviour at the register or pin boundary.
  a_dir_reset_clear: assert property (@(posedge clk_i) rst_i |=>
    (third_port_direction_q == 8'h00 && fourth_port_direction_q == 8'h00))
    else $error("direction not cleared by reset");
  // Case equality here, because the latches stay unknown until first written.
  a_latch_keep_reset: assert property (@(posedge clk_i)
    (rst_i && !wr_lane0) |=> third_port_data_q === $past(third_port_data_q) &&
    fourth_port_data_q === $past(fourth_port_data_q))
    else $error("latch changed over reset");
  a_data_write_in: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_lane0 && idx == IDX_THIRD_DATA) |=> third_port_data_q == $past(wb_dat_i[7:0]))
    else $error("third latch write lost");
  a_fourth_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_lane0 && idx == IDX_FOURTH_DATA) |=> fourth_port_data_q == $past(wb_dat_i[7:0]))
    else $error("fourth latch write lost");
  a_read_third: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && hit && !wb_we_i && idx == IDX_THIRD_DATA) |=> wb_ack_o &&
    wb_dat_o[7:0] == (($past(third_port_direction_q) & $past(third_port_data_q)) |
    (~$past(third_port_direction_q) & $past(third_sync_q))))
    else $error("third port read wrong");
  a_dir_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && hit && !wb_we_i && idx == IDX_FOURTH_DIR) |=>
    wb_dat_o[7:0] == $past(fourth_port_direction_q))
    else $error("direction readback wrong");
  a_spi_override: assert property (@(posedge clk_i) disable iff (rst_i)
    serial_periph_enable |-> third_pin_oe_o[PIN_MOSI] == spi_mosi_oe_i)
    else $error("serial override missing");
  a_ir_override: assert property (@(posedge clk_i) disable iff (rst_i)
    infrared_serial_enable |-> third_pin_oe_o[PIN_IR_TX] && !third_pin_oe_o[PIN_IR_RX])
    else $error("infrared override missing");
  a_fourth_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    fourth_pin_oe_o == fourth_port_direction_q)
    else $error("fourth port drive wrong");
  a_kbd_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(keyboard_irq_enable_reg_q[0]) |-> !keyboard_irq_o[0])
    else $error("keyboard gate open");

  // Bus handshake in named steps; each taken request gets exactly one answer pulse.
  // No request is taken while the answer is up, so a master that still holds stb sees a second one only two cycles later.
  sequence s_take_hit;
    req && hit;
  endsequence

  sequence s_take_miss;
    req && !hit;
  endsequence

  sequence s_ack_pulse;
    wb_ack_o && !wb_err_o ##1 !wb_ack_o;
  endsequence

  sequence s_err_pulse;
    wb_err_o && !wb_ack_o ##1 !wb_err_o;
  endsequence

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    s_take_hit |=> s_ack_pulse)
    else $error("acknowledge not a single pulse");
  a_err_single: assert property (@(posedge clk_i) disable iff (rst_i)
    s_take_miss |=> s_err_pulse)
    else $error("error answer not a single pulse");

  // A write answer carries an all-zero word, so old read data never reappears.
  a_write_no_data: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && hit && wb_we_i) |=> wb_dat_o == 32'h0000_0000)
    else $error("write answer carries data");
  a_dir_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_lane0 && idx == IDX_THIRD_DIR) |=> third_port_direction_q == $past(wb_dat_i[7:0]))
    else $error("third direction write lost");

  // Second and fourth port reads follow the same per-bit blend as the third.
  a_read_second: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && hit && !wb_we_i && idx == IDX_SECOND_DATA) |=> wb_ack_o &&
    wb_dat_o[7:0] == (($past(second_port_direction_q) & $past(second_port_data_q)) |
    (~$past(second_port_direction_q) & $past(second_sync_q))))
    else $error("second port read wrong");
  a_read_fourth: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && hit && !wb_we_i && idx == IDX_FOURTH_DATA) |=> wb_ack_o &&
    wb_dat_o[7:0] == (($past(fourth_port_direction_q) & $past(fourth_port_data_q)) |
    (~$past(fourth_port_direction_q) & $past(fourth_sync_q))))
    else $error("fourth port read wrong");

  // With both peripherals off the third port drive follows its direction bits alone.
  a_third_plain: assert property (@(posedge clk_i) disable iff (rst_i)
    (!serial_periph_enable && !infrared_serial_enable) |->
    third_pin_oe_o == third_port_direction_q)
    else $error("third port drive wrong");

  // Under override the peripheral owns the drive and sees synchronised levels.
  a_spi_lines: assert property (@(posedge clk_i) disable iff (rst_i)
    serial_periph_enable |-> third_pin_o[PIN_SCK] == spi_sck_out_i &&
    third_pin_oe_o[PIN_SCK] == spi_sck_oe_i && spi_pins_o == third_sync_q[PIN_SCK:PIN_MISO])
    else $error("serial lines wrong");
  a_ir_lines: assert property (@(posedge clk_i) disable iff (rst_i)
    infrared_serial_enable |-> third_pin_o[PIN_IR_TX] == infrared_transmit_line_i &&
    infrared_receive_line_o == third_sync_q[PIN_IR_RX])
    else $error("infrared lines wrong");

  // The interrupt feed sees pin 0 two edges late whatever the port does with it.
  a_irq_feed: assert property (@(posedge clk_i) disable iff (rst_i)
    second_external_interrupt_o == $past(third_pin_i[PIN_SECOND_EXTERNAL_INTERRUPT], 2))
    else $error("interrupt feed wrong");
  a_pullup_ctrl: assert property (@(posedge clk_i) disable iff (rst_i)
    third_pin0_pullup_o == !periph_ctrl_q[BIT_PULLUP_DIS])
    else $error("pullup control wrong");

  // The keyboard feed is the synchronised pin masked by its own enable bit.
  a_kbd_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    keyboard_irq_o == ($past(fourth_pin_i, 2) & keyboard_irq_enable_reg_q))
    else $error("keyboard feed wrong");

endmodule // gpb_ports

//--- gpb_board.sv
`timescale 1ns/1ns
// Board side of all three ports: a pin shows the chip drive while enabled, else the board level.
module gpb_board
(
  // Chip side.
  input  wire logic [23:0] drv_i,
  input  wire logic [23:0] oe_i,
  // Board side.
  input  wire logic [23:0] ext_i,
  output logic      [23:0] lvl_o
);
  // Each pin resolves alone, so a mixed direction word still reads correctly.
  always_comb
  begin
    for (int i = 0; i < 24; i++)
    begin
      lvl_o[i] = oe_i[i] ? drv_i[i] : ext_i[i];
    end
  end
endmodule // gpb_board

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top
  import gpb_pkg::*;
;
  logic        clk_i, rst_i, cyc, stb, we, berr, ir_tx, ack, err, pu, ir_rx, second_external_interrupt;
  logic [5:0]  adr;
  logic [3:0]  sel, so, soe, spi_pins;
  logic [31:0] wdat, rdat, dat_o;
  logic [7:0]  kbd, kbd_en;
  logic [23:0] drv, oe, ext, lvl;
  int          failures, compares;

  gpb_ports dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .wb_err_o(err), .second_pin_i(lvl[7:0]), .second_pin_o(drv[7:0]),
    .second_pin_oe_o(oe[7:0]), .third_pin_i(lvl[15:8]), .third_pin_o(drv[15:8]),
    .third_pin_oe_o(oe[15:8]), .third_pin0_pullup_o(pu), .fourth_pin_i(lvl[23:16]),
    .fourth_pin_o(drv[23:16]), .fourth_pin_oe_o(oe[23:16]), .spi_miso_out_i(so[0]),
    .spi_miso_oe_i(soe[0]), .spi_mosi_out_i(so[1]), .spi_mosi_oe_i(soe[1]),
    .spi_ss_out_i(so[2]), .spi_ss_oe_i(soe[2]), .spi_sck_out_i(so[3]), .spi_sck_oe_i(soe[3]),
    .spi_pins_o(spi_pins), .infrared_transmit_line_i(ir_tx), .infrared_receive_line_o(ir_rx),
    .second_external_interrupt_o(second_external_interrupt), .keyboard_irq_o(kbd), .keyboard_irq_enable_bits_o(kbd_en));

  gpb_board board (.drv_i(drv), .oe_i(oe), .ext_i(ext), .lvl_o(lvl));

  // Free-running 125 MHz clock.
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One classic cycle; waits for ack or err since the slave decides its own latency.
  task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    do
      @(posedge clk_i);
    while (ack !== 1'b1 && err !== 1'b1);
    rdat = dat_o;
    berr = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rchk(input string what, input logic [3:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(what, exp, rdat[7:0]);
  endtask

  // Pin inputs pass a two-flop synchroniser, so give them a few edges.
  task automatic settle();
    repeat (4) @(posedge clk_i);
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic t_reset();
    rchk("third dir", IDX_THIRD_DIR, 8'h00);
    rchk("fourth dir", IDX_FOURTH_DIR, 8'h00);
    chk("oe", 8'h00, oe[15:8] | oe[23:16]);
  endtask

  // Input pins read the board, output pins the latch; the latch always takes writes.
  task automatic t_ports();
    for (int p = 0; p < 3; p++)
    begin
      ext[p*8 +: 8] <= 8'h5a;
      wb(1'b1, IDX_SECOND_DATA + 4'(p), 8'ha5);
      settle();
      rchk("pins in", IDX_SECOND_DATA + 4'(p), 8'h5a);
      wb(1'b1, IDX_SECOND_DIR + 4'(p), 8'h0f);
      rchk("dir", IDX_SECOND_DIR + 4'(p), 8'h0f);
      rchk("mixed", IDX_SECOND_DATA + 4'(p), 8'h55);
      chk("oe", 8'h0f, oe[p*8 +: 8]);
      chk("drive", 8'h05, drv[p*8 +: 8] & 8'h0f);
      wb(1'b1, IDX_SECOND_DATA + 4'(p), 8'hc3);
      rchk("rewrite", IDX_SECOND_DATA + 4'(p), 8'h53);
    end
  endtask

  // Latches survive reset while directions drop back to input.
  task automatic t_keep();
    wb(1'b1, IDX_THIRD_DATA, 8'h3c);
    wb(1'b1, IDX_FOURTH_DATA, 8'h3c);
    do_reset();
    rchk("third dir", IDX_THIRD_DIR, 8'h00);
    rchk("fourth dir", IDX_FOURTH_DIR, 8'h00);
    wb(1'b1, IDX_THIRD_DIR, 8'hff);
    wb(1'b1, IDX_FOURTH_DIR, 8'hff);
    rchk("third keep", IDX_THIRD_DATA, 8'h3c);
    rchk("fourth keep", IDX_FOURTH_DATA, 8'h3c);
  endtask

  // Peripheral overrides, the interrupt feed, pullup and keyboard enables.
  task automatic t_periph();
    so <= 4'b0101;
    soe <= 4'b1100;
    ir_tx <= 1'b0;
    ext[15:8] <= 8'hda;
    wb(1'b1, IDX_PERIPH_CTRL, 8'h03);
    settle();
    chk("spi oe", 8'h0c, {4'h0, oe[13:10]});
    chk("spi in", 8'h06, {4'h0, spi_pins});
    chk("ir tx", 8'h02, {6'h00, oe[14], drv[14]});
    chk("ir rx", 8'h01, {7'h00, ir_rx});
    chk("irq low", 8'h00, {7'h00, second_external_interrupt});
    chk("pullup", 8'h01, {7'h00, pu});
    wb(1'b1, IDX_THIRD_DATA, 8'h3d);
    wb(1'b1, IDX_PERIPH_CTRL, 8'h04);
    settle();
    chk("spi off", 8'h0f, {4'h0, spi_pins});
    chk("irq high", 8'h01, {7'h00, second_external_interrupt});
    chk("pullup off", 8'h00, {7'h00, pu});
    ext[23:16] <= 8'hff;
    wb(1'b1, IDX_FOURTH_DIR, 8'h00);
    wb(1'b1, IDX_KBD_ENABLE, 8'hff);
    settle();
    chk("kbd all", 8'hff, kbd);
    wb(1'b1, IDX_KBD_ENABLE, 8'hf0);
    settle();
    chk("kbd", 8'hf0, kbd);
    chk("kbd en", 8'hf0, kbd_en);
    wb(1'b1, 4'hf, 8'h00);
    chk("unmapped", 8'h01, {7'h00, berr});
  endtask

  // Main sequence.
  initial
  begin
    {rst_i, cyc, stb, we, ir_tx} = 5'b10000;
    {adr, wdat, so, soe, ext} = '0;
    sel = 4'h1;
    failures = 0;
    compares = 0;
    do_reset();
    @(posedge clk_i);
    t_reset();
    t_ports();
    t_keep();
    t_periph();
    end_of_test();
  end

  // Watchdog; the whole run needs well under a thousand cycles.
  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    end_of_test();
  end
endmodule // tb_top
